// ===== dv/ext_ref_model.sv
/*
  Far-side model of the external reference: crystal or precision source
  feeding the loop, giving lock, reference-lost and DCO-stable levels.
  Assumes the bench commands reference presence and lock upsets by clk.
*/
`timescale 1ns/10ps
`default_nettype none

module ext_ref_model (
  input wire logic clk,
  input wire logic refRunning,
  input wire logic lockUpset,
  output logic fllLock,
  output logic refClockLost,
  output logic dcoStable
);
  logic [3:0] settle_q;

  // the loop needs time to settle after any upset, so lock is never instant
  always_ff @(posedge clk) begin
    if (!refRunning || lockUpset) begin
      settle_q <= 4'h0;
    end else if (settle_q != 4'hF) begin
      settle_q <= settle_q + 4'h1;
    end
  end

  assign fllLock = (settle_q == 4'hF);
  assign refClockLost = !refRunning;
  assign dcoStable = fllLock;
endmodule // ext_ref_model

`default_nettype wire

// ===== dv/tb.sv
/*
  Self-checking bench for the clock generator configuration block.
  Assumes APB with one setup and one access cycle and the far-side model.
*/
`timescale 1ns/10ps
`default_nettype none

module tb;
  localparam int unsigned EXT_HZ = 4000000;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic refRunning = 1'b0;
  logic lockUpset = 1'b0;
  logic stopMode = 1'b0;
  logic fllLock, refClockLost, dcoStable, pready, pslverr, oscGainSelect, oscEnable;
  logic crystalRequest, lostClockDetectEnable, irqRequest, resetRequest, oscillatorStable;
  logic [31:0] prdata, generatorHz, busHz, rdata;
  logic [1:0] clockMode;
  logic [6:0] prescaleFactor;
  logic [4:0] multiplyFactor;
  logic [7:0] divideFactor, trimValue;
  logic rerr, sawIrq, sawRst;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;

  always #2 clk = ~clk;

  clock_gen_config #(.EXT_REF_HZ(EXT_HZ)) DUT (.clk(clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fllLock(fllLock), .refClockLost(refClockLost),
    .dcoStable(dcoStable), .stopMode(stopMode), .clockMode(clockMode),
    .oscGainSelect(oscGainSelect), .oscEnable(oscEnable), .crystalRequest(crystalRequest),
    .lostClockDetectEnable(lostClockDetectEnable), .prescaleFactor(prescaleFactor),
    .multiplyFactor(multiplyFactor), .divideFactor(divideFactor), .trimValue(trimValue),
    .generatorHz(generatorHz), .busHz(busHz), .irqRequest(irqRequest),
    .resetRequest(resetRequest), .oscillatorStable(oscillatorStable));

  ext_ref_model partner (.clk(clk), .refRunning(refRunning), .lockUpset(lockUpset),
    .fllLock(fllLock), .refClockLost(refClockLost), .dcoStable(dcoStable));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test;
    if (fails == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      end_of_test();
    end
  end

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // frequency outputs settle one cycle after the write lands
  task automatic cfg(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h00_0000, d});
    repeat (3) @(posedge clk);
  endtask

  task automatic doReset;
    rstn <= 1'b0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  task automatic waitEvent;
    sawIrq = 1'b0;
    sawRst = 1'b0;
    repeat (12) begin
      @(posedge clk);
      if (irqRequest === 1'b1) sawIrq = 1'b1;
      if (resetRequest === 1'b1) sawRst = 1'b1;
    end
  endtask

  task automatic clearIrq;
    cfg(clock_gen_pkg::STATUS1_OFFSET, 8'h01);
    check("irq cleared", irqRequest, 32'h0000_0000);
  endtask

  task automatic near(input real e);
    real diff;
    diff = generatorHz - e;
    check("hz near", (diff < 8.0 && diff > -8.0), 32'h0000_0001);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic resetValues;
    check("gen hz", generatorHz, 32'h007A_1200);
    check("bus hz", busHz, 32'h003D_0900);
    check("mode", clockMode, 32'h0000_0000);
    apb(1'b0, clock_gen_pkg::TRIM_OFFSET, 32'h0000_0000);
    check("trim", rdata, 32'h0000_0080);
    apb(1'b1, 8'h20, 32'h0000_00FF);
    apb(1'b0, 8'h20, 32'h0000_0000);
    check("unmapped", {rerr, rdata[30:0]}, 32'h8000_0000);
    cfg(clock_gen_pkg::STATUS2_OFFSET, 8'h01);
    apb(1'b0, clock_gen_pkg::STATUS2_OFFSET, 32'h0000_0000);
    check("status two ro", rdata, 32'h0000_0000);
  endtask

  task automatic extLockSetup;
    refRunning <= 1'b1;
    cfg(clock_gen_pkg::CTRL1_OFFSET, 8'h79);
    cfg(clock_gen_pkg::CTRL2_OFFSET, 8'h30);
    check("mode ext lock", clockMode, 32'h0000_0003);
    check("prescale", prescaleFactor, 32'h0000_0001);
    check("mult", multiplyFactor, 32'h0000_000A);
    check("ext lock hz", generatorHz, 32'h0262_5A00);
    check("ext lock bus", busHz, 32'h0131_2D00);
    check("xtal req", crystalRequest, 32'h0000_0001);
    check("low gain", oscGainSelect, 32'h0000_0000);
    check("detect on", lostClockDetectEnable, 32'h0000_0001);
    cfg(clock_gen_pkg::CTRL1_OFFSET, 8'hB8);
    check("high gain", oscGainSelect, 32'h0000_0001);
    apb(1'b0, clock_gen_pkg::CTRL1_OFFSET, 32'h0000_0000);
    check("ctrl1 once", rdata, 32'h0000_00F8);
    check("range kept", prescaleFactor, 32'h0000_0001);
    cfg(clock_gen_pkg::CTRL1_OFFSET, 8'h78);
    for (int c = 0; c < 8; c++) begin
      cfg(clock_gen_pkg::CTRL2_OFFSET, {5'b0_0110, c[2:0]});
      check("div", divideFactor, 32'h0000_0001 << c);
      check("div hz", generatorHz, 32'h0262_5A00 >> c);
    end
    cfg(clock_gen_pkg::CTRL2_OFFSET, 8'h30);
    repeat (20) @(posedge clk);
    apb(1'b0, clock_gen_pkg::STATUS2_OFFSET, 32'h0000_0000);
    check("dco stable", rdata, 32'h0000_0001);
    check("osc stable", oscillatorStable, 32'h0000_0001);
  endtask

  task automatic stopKeep;
    stopMode <= 1'b1;
    repeat (5) @(posedge clk);
    check("osc off stop", oscEnable, 32'h0000_0000);
    cfg(clock_gen_pkg::CTRL1_OFFSET, 8'h7C);
    check("osc kept", oscEnable, 32'h0000_0001);
    stopMode <= 1'b0;
    cfg(clock_gen_pkg::CTRL1_OFFSET, 8'h78);
  endtask

  task automatic lossEvents;
    lockUpset <= 1'b1;
    @(posedge clk);
    lockUpset <= 1'b0;
    waitEvent();
    check("lol irq", {sawIrq, sawRst}, 32'h0000_0002);
    apb(1'b0, clock_gen_pkg::STATUS1_OFFSET, 32'h0000_0000);
    check("status1", {rdata[4], rdata[0]}, 32'h0000_0003);
    clearIrq();
    repeat (20) @(posedge clk);
    cfg(clock_gen_pkg::CTRL2_OFFSET, 8'hB0);
    lockUpset <= 1'b1;
    @(posedge clk);
    lockUpset <= 1'b0;
    waitEvent();
    check("lol reset", {sawIrq, sawRst}, 32'h0000_0001);
    cfg(clock_gen_pkg::CTRL2_OFFSET, 8'h38);
    repeat (20) @(posedge clk);
    refRunning <= 1'b0;
    waitEvent();
    check("loc reset", sawRst, 32'h0000_0001);
    clearIrq();
    refRunning <= 1'b1;
    cfg(clock_gen_pkg::CTRL2_OFFSET, 8'h30);
    repeat (20) @(posedge clk);
    refRunning <= 1'b0;
    waitEvent();
    check("loc irq", {sawIrq, sawRst}, 32'h0000_0002);
    clearIrq();
    refRunning <= 1'b1;
    cfg(clock_gen_pkg::CTRL2_OFFSET, 8'h38);
    cfg(clock_gen_pkg::CTRL1_OFFSET, 8'h7A);
    check("detect off", lostClockDetectEnable, 32'h0000_0000);
    repeat (20) @(posedge clk);
    refRunning <= 1'b0;
    waitEvent();
    check("loc ignored", sawRst, 32'h0000_0000);
  endtask

  task automatic intLockSetup;
    refRunning <= 1'b1;
    cfg(clock_gen_pkg::CTRL1_OFFSET, 8'h08);
    check("mode int lock", clockMode, 32'h0000_0001);
    check("xtal unused", crystalRequest, 32'h0000_0000);
    check("int lock p", prescaleFactor, 32'h0000_0040);
    // trimming runs with the divider at 4 so the output cannot overshoot
    cfg(clock_gen_pkg::CTRL2_OFFSET, 8'h32);
    cfg(clock_gen_pkg::TRIM_OFFSET, 8'h00);
    check("trim val", trimValue, 32'h0000_0000);
    near(243000.0 * 0.75 / 7.0 * 640.0 / 4.0);
    cfg(clock_gen_pkg::TRIM_OFFSET, 8'h80);
    near(243000.0 / 7.0 * 640.0 / 4.0);
    cfg(clock_gen_pkg::CTRL2_OFFSET, 8'h31);
    near(243000.0 / 7.0 * 640.0 / 2.0);
  endtask

  task automatic otherModes;
    doReset();
    cfg(clock_gen_pkg::CTRL1_OFFSET, 8'h10);
    check("bypass", clockMode, 32'h0000_0002);
    check("bypass hz", generatorHz, EXT_HZ);
    doReset();
    cfg(clock_gen_pkg::CTRL1_OFFSET, 8'h00);
    cfg(clock_gen_pkg::CTRL1_OFFSET, 8'h18);
    check("self kept", clockMode, 32'h0000_0000);
    check("low range", prescaleFactor, 32'h0000_0040);
    cfg(clock_gen_pkg::CTRL2_OFFSET, 8'h01);
    check("self div", busHz, 32'h001E_8480);
  endtask

  initial begin
    doReset();
    resetValues();
    extLockSetup();
    stopKeep();
    lossEvents();
    intLockSetup();
    otherModes();
    end_of_test();
  end
endmodule // tb

`default_nettype wire

// ===== rtl/clock_gen_config.sv
/*
  Configuration and status logic of the internal clock generator, reached over APB.
  Holds the two control registers and the trim register, reports status, computes
  the resulting generator and bus frequency, and turns lock and reference loss into
  interrupt or reset requests. Assumes lock, reference-loss, DCO-stable and stop
  indications arrive asynchronously from the analog macro.
*/
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - out of reset: self-clocked mode, about 8 MHz out, 4 MHz bus.
// - bus frequency is half the generator output frequency.
// - locked external: fext times P times N divided by R.
// - locked internal: reference over 7, times 64, times N, over R.
// - control one bit 6: 1 gives high range P=1, 0 low range P=64.
// - mode field bits 4:3: 11 locked external, 01 locked internal.
// - multiply field bits 6:4 of control two; code 011 gives N=10.
// - divide field bits 2:0; code 000 divides by 1, 001 by 2.
// - control one bit 7 at 0 selects low-power oscillator.
// - bit 5 requests crystal oscillator; ignored in locked internal mode.
// - bit 2 at 0 keeps the external oscillator off in stop.
// - bit 1 at 0 enables lost reference clock detection.
// - control two bit 7 at 0: lock loss interrupts, else resets.
// - control two bit 3 at 0: clock loss interrupts, else resets.
// - control one bit 0 reads zero, writes ignored.
// - status one is read-only except writing bit 0 clears the interrupt, lost-lock and lost-clock flags.
// - status two read-only, shows DCO stable; software checks it first.
// - untrimmed reference within 25 percent; trim tightens it.
// - internal reference runs near 243 kHz, multiplied in internal mode.
// - mode code 00 self-clocked, 10 bypassed external reference.
// - range bit writable once after each reset.
module clock_gen_config #(
  parameter int unsigned EXT_REF_HZ = 4000000
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [clock_gen_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fllLock,
  input wire logic refClockLost,
  input wire logic dcoStable,
  input wire logic stopMode,
  output logic [1:0] clockMode,
  output logic oscGainSelect,
  output logic oscEnable,
  output logic crystalRequest,
  output logic lostClockDetectEnable,
  output logic [6:0] prescaleFactor,
  output logic [4:0] multiplyFactor,
  output logic [7:0] divideFactor,
  output logic [7:0] trimValue,
  output logic [31:0] generatorHz,
  output logic [31:0] busHz,
  output logic irqRequest,
  output logic resetRequest,
  output logic oscillatorStable
);

  if (EXT_REF_HZ == 0 || EXT_REF_HZ > 40000000) begin : badRefCheck
    $error("EXT_REF_HZ out of range");
  end

  // ****************************************
  // reset release
  // ****************************************
  logic [1:0] rstPipe;
  logic rstSync;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstPipe <= 2'b00;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstSync = rstPipe[1];

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [clock_gen_pkg::SYNC_W-1:0] syncA;
    logic [clock_gen_pkg::SYNC_W-1:0] syncB;
    logic lockPrev;
    logic lostPrev;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [7:0] trim;
    logic rangeWritten;
    logic refselWritten;
    logic modeWritten;
    logic extBlocked;
    logic irqFlag;
    logic lostLockSt;
    logic lostClkSt;
    logic resetReq;
    logic [31:0] prdata;
    logic [31:0] genHz;
  } state_t;

  localparam state_t STATE_RESET = '{
    syncA: '0, syncB: '0, lockPrev: 1'b0, lostPrev: 1'b0,
    ctrl1: clock_gen_pkg::CTRL1_RESET, ctrl2: clock_gen_pkg::CTRL2_RESET,
    trim: clock_gen_pkg::TRIM_RESET, rangeWritten: 1'b0, refselWritten: 1'b0,
    modeWritten: 1'b0, extBlocked: 1'b0, irqFlag: 1'b0, lostLockSt: 1'b0,
    lostClkSt: 1'b0, resetReq: 1'b0, prdata: '0, genHz: clock_gen_pkg::SELF_CLOCK_HZ
  };

  state_t q;
  state_t d;

  // ****************************************
  // frequency arithmetic
  // ****************************************
  function automatic logic [4:0] multDecode(input logic [2:0] code);
    multDecode = clock_gen_pkg::MULT_BASE + {1'b0, code, 1'b0};
  endfunction

  function automatic logic [6:0] prescaleOf(input logic [1:0] mode, input logic range);
    if (mode == clock_gen_pkg::MODE_LOCK_INT) begin
      prescaleOf = clock_gen_pkg::PRESCALE_INT;
    end else begin
      prescaleOf = range ? clock_gen_pkg::PRESCALE_HIGH : clock_gen_pkg::PRESCALE_LOW;
    end
  endfunction

  function automatic logic [31:0] genFreq(input logic [1:0] mode, input logic range,
                                          input logic [2:0] multCode, input logic [2:0] divCode,
                                          input logic [7:0] trim);
    logic [63:0] refHz;
    logic [63:0] base;
    logic [63:0] n;
    logic [63:0] p;
    n = {59'h0, multDecode(multCode)};
    p = {57'h0, prescaleOf(mode, range)};
    // trim spans 0.75 to 1.25 of nominal around the mid code
    refHz = ({32'h0, clock_gen_pkg::REF_GEN_HZ} * (clock_gen_pkg::TRIM_SPAN_BASE + {56'h0, trim}))
            / clock_gen_pkg::TRIM_SPAN_DIV;
    unique case (mode)
      clock_gen_pkg::MODE_SELF: base = {32'h0, clock_gen_pkg::SELF_CLOCK_HZ};
      // multiply before dividing by 7 so truncation costs under 1 Hz
      clock_gen_pkg::MODE_LOCK_INT: base = (refHz * p * n) / clock_gen_pkg::INT_REF_DIV;
      clock_gen_pkg::MODE_BYPASS_EXT: base = 64'(EXT_REF_HZ);
      clock_gen_pkg::MODE_LOCK_EXT: base = 64'(EXT_REF_HZ) * p * n;
    endcase
    // divide before cutting to 32 bits; a setting that still needs more wraps
    base = base >> divCode;
    genFreq = base[31:0];
  endfunction

  // ****************************************
  // next state
  // ****************************************
  logic setupPhase;
  logic writeAccess;
  logic mapped;
  logic lockLoss;
  logic clkLoss;
  logic [1:0] mode;
  logic [7:0] wbyte;
  logic [1:0] wmode;

  always_comb begin
    d = q;
    setupPhase = psel && !penable;
    writeAccess = psel && penable && pwrite;
    mapped = (paddr == clock_gen_pkg::CTRL1_OFFSET) || (paddr == clock_gen_pkg::CTRL2_OFFSET) ||
             (paddr == clock_gen_pkg::STATUS1_OFFSET) || (paddr == clock_gen_pkg::STATUS2_OFFSET) ||
             (paddr == clock_gen_pkg::TRIM_OFFSET);
    mode = q.ctrl1[clock_gen_pkg::MODE_HI:clock_gen_pkg::MODE_LO];
    wbyte = pwdata[7:0];
    wmode = wbyte[clock_gen_pkg::MODE_HI:clock_gen_pkg::MODE_LO];

    // the first stage feeds only the second
    d.syncA = {stopMode, dcoStable, refClockLost, fllLock};
    d.syncB = q.syncA;
    d.lockPrev = q.syncB[clock_gen_pkg::SYNC_LOCK];
    d.lostPrev = q.syncB[clock_gen_pkg::SYNC_LOST];

    // lock only matters while the loop is engaged
    lockLoss = q.lockPrev && !q.syncB[clock_gen_pkg::SYNC_LOCK] && mode[0];
    clkLoss = !q.lostPrev && q.syncB[clock_gen_pkg::SYNC_LOST] &&
              !q.ctrl1[clock_gen_pkg::DETECT_OFF_BIT] && (mode != clock_gen_pkg::MODE_SELF);

    d.resetReq = (lockLoss && q.ctrl2[clock_gen_pkg::LOCK_RST_BIT]) ||
                 (clkLoss && q.ctrl2[clock_gen_pkg::CLK_RST_BIT]);

    // clear first so that a simultaneous event still sets the flag
    if (writeAccess && paddr == clock_gen_pkg::STATUS1_OFFSET && wbyte[clock_gen_pkg::IRQ_FLAG_BIT]) begin
      d.irqFlag = 1'b0;
      d.lostLockSt = 1'b0;
      d.lostClkSt = 1'b0;
    end
    if (lockLoss) begin
      d.lostLockSt = 1'b1;
    end
    if (clkLoss) begin
      d.lostClkSt = 1'b1;
    end
    if ((lockLoss && !q.ctrl2[clock_gen_pkg::LOCK_RST_BIT]) ||
        (clkLoss && !q.ctrl2[clock_gen_pkg::CLK_RST_BIT])) begin
      d.irqFlag = 1'b1;
    end

    if (writeAccess && paddr == clock_gen_pkg::CTRL1_OFFSET) begin
      d.ctrl1[clock_gen_pkg::GAIN_BIT] = wbyte[clock_gen_pkg::GAIN_BIT];
      d.ctrl1[clock_gen_pkg::STOPKEEP_BIT] = wbyte[clock_gen_pkg::STOPKEEP_BIT];
      d.ctrl1[clock_gen_pkg::DETECT_OFF_BIT] = wbyte[clock_gen_pkg::DETECT_OFF_BIT];
      d.ctrl1[clock_gen_pkg::UNIMPL_BIT] = 1'b0;
      if (!q.rangeWritten) begin
        d.ctrl1[clock_gen_pkg::RANGE_BIT] = wbyte[clock_gen_pkg::RANGE_BIT];
        d.rangeWritten = 1'b1;
      end
      if (!q.refselWritten) begin
        d.ctrl1[clock_gen_pkg::REFSEL_BIT] = wbyte[clock_gen_pkg::REFSEL_BIT];
        d.refselWritten = 1'b1;
      end
      // external pin stays unreserved if the first mode write chose an internal mode
      if (!(q.extBlocked && wmode[1])) begin
        d.ctrl1[clock_gen_pkg::MODE_HI:clock_gen_pkg::MODE_LO] = wmode;
      end
      if (!q.modeWritten) begin
        d.modeWritten = 1'b1;
        d.extBlocked = !wmode[1];
      end
    end
    if (writeAccess && paddr == clock_gen_pkg::CTRL2_OFFSET) begin
      d.ctrl2 = wbyte;
    end
    if (writeAccess && paddr == clock_gen_pkg::TRIM_OFFSET) begin
      d.trim = wbyte;
    end

    // read data is fetched in setup so the access phase needs no wait
    if (setupPhase) begin
      d.prdata = '0;
      unique case (paddr)
        clock_gen_pkg::CTRL1_OFFSET: d.prdata[7:0] = q.ctrl1;
        clock_gen_pkg::CTRL2_OFFSET: d.prdata[7:0] = q.ctrl2;
        clock_gen_pkg::STATUS1_OFFSET: begin
          d.prdata[clock_gen_pkg::IRQ_FLAG_BIT] = q.irqFlag;
          d.prdata[clock_gen_pkg::LOST_CLK_BIT] = q.lostClkSt;
          d.prdata[clock_gen_pkg::LOCK_BIT] = q.syncB[clock_gen_pkg::SYNC_LOCK];
          d.prdata[clock_gen_pkg::LOST_LOCK_BIT] = q.lostLockSt;
        end
        clock_gen_pkg::STATUS2_OFFSET: d.prdata[clock_gen_pkg::STABLE_BIT] = q.syncB[clock_gen_pkg::SYNC_DCO];
        clock_gen_pkg::TRIM_OFFSET: d.prdata[7:0] = q.trim;
        default: d.prdata = '0;
      endcase
    end

    d.genHz = genFreq(mode, q.ctrl1[clock_gen_pkg::RANGE_BIT],
                      q.ctrl2[clock_gen_pkg::MULT_HI:clock_gen_pkg::MULT_LO],
                      q.ctrl2[clock_gen_pkg::DIV_HI:clock_gen_pkg::DIV_LO], q.trim);
  end

  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      q <= STATE_RESET;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign prdata = q.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign clockMode = q.ctrl1[clock_gen_pkg::MODE_HI:clock_gen_pkg::MODE_LO];
  assign oscGainSelect = q.ctrl1[clock_gen_pkg::GAIN_BIT];
  // the oscillator serves external modes only; stop turns it off unless kept
  assign oscEnable = clockMode[1] &&
                     (!q.syncB[clock_gen_pkg::SYNC_STOP] || q.ctrl1[clock_gen_pkg::STOPKEEP_BIT]);
  assign crystalRequest = clockMode[1] && q.ctrl1[clock_gen_pkg::REFSEL_BIT];
  assign lostClockDetectEnable = !q.ctrl1[clock_gen_pkg::DETECT_OFF_BIT];
  assign prescaleFactor = prescaleOf(clockMode, q.ctrl1[clock_gen_pkg::RANGE_BIT]);
  assign multiplyFactor = multDecode(q.ctrl2[clock_gen_pkg::MULT_HI:clock_gen_pkg::MULT_LO]);
  assign divideFactor = 8'h01 << q.ctrl2[clock_gen_pkg::DIV_HI:clock_gen_pkg::DIV_LO];
  assign trimValue = q.trim;
  assign generatorHz = q.genHz;
  assign busHz = {1'b0, q.genHz[31:1]};
  assign irqRequest = q.irqFlag;
  assign resetRequest = q.resetReq;
  assign oscillatorStable = q.syncB[clock_gen_pkg::SYNC_DCO];

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSync);

  logic lockLossSeen;
  assign lockLossSeen = q.lockPrev && !q.syncB[clock_gen_pkg::SYNC_LOCK] && clockMode[0];

  unimpl_zero_a: assert property (
    psel && !penable && paddr == clock_gen_pkg::CTRL1_OFFSET |=> prdata[clock_gen_pkg::UNIMPL_BIT] == 1'b0)
    else $error("control one bit 0 not zero");
  range_once_a: assert property (q.rangeWritten |=> $stable(q.ctrl1[clock_gen_pkg::RANGE_BIT]))
    else $error("range changed after first write");
  lock_irq_a: assert property (
    lockLossSeen && !q.ctrl2[clock_gen_pkg::LOCK_RST_BIT] |=> irqRequest && !resetRequest)
    else $error("lock loss did not interrupt");
  lock_reset_a: assert property (
    lockLossSeen && q.ctrl2[clock_gen_pkg::LOCK_RST_BIT] |=> resetRequest ##1 !resetRequest)
    else $error("lock loss did not pulse reset");
  clk_irq_a: assert property (
    $rose(q.syncB[clock_gen_pkg::SYNC_LOST]) && lostClockDetectEnable && clockMode != clock_gen_pkg::MODE_SELF
    && !q.ctrl2[clock_gen_pkg::CLK_RST_BIT] |=> irqRequest) else $error("clock loss did not interrupt");
  clk_reset_a: assert property (
    $rose(q.syncB[clock_gen_pkg::SYNC_LOST]) && lostClockDetectEnable && clockMode != clock_gen_pkg::MODE_SELF
    && q.ctrl2[clock_gen_pkg::CLK_RST_BIT] |=> resetRequest) else $error("clock loss did not reset");
  bus_half_a: assert property (busHz * 2 + {31'h0, generatorHz[0]} == generatorHz)
    else $error("bus not half of generator");
  self_freq_a: assert property (
    (clockMode == clock_gen_pkg::MODE_SELF && divideFactor == 8'h01) [*2]
    |-> generatorHz == clock_gen_pkg::SELF_CLOCK_HZ) else $error("self-clocked output not 8 MHz");
  range_high_a: assert property (
    clockMode == clock_gen_pkg::MODE_LOCK_EXT && q.ctrl1[clock_gen_pkg::RANGE_BIT]
    |-> prescaleFactor == clock_gen_pkg::PRESCALE_HIGH) else $error("high range prescale not 1");
  stop_off_a: assert property (
    q.syncB[clock_gen_pkg::SYNC_STOP] && !q.ctrl1[clock_gen_pkg::STOPKEEP_BIT] |-> !oscEnable)
    else $error("oscillator on in stop");
  int_nocrystal_a: assert property (clockMode == clock_gen_pkg::MODE_LOCK_INT |-> !crystalRequest)
    else $error("crystal requested in internal mode");
  stable_read_a: assert property (
    psel && !penable && paddr == clock_gen_pkg::STATUS2_OFFSET |=> prdata == {31'h0, $past(oscillatorStable)})
    else $error("status two wrong");
  mode_block_a: assert property (q.extBlocked |-> !clockMode[1])
    else $error("external mode taken after internal first write");

  ext_lock_c: cover property (clockMode == clock_gen_pkg::MODE_LOCK_EXT && multiplyFactor == 5'h0A);
  int_lock_c: cover property (clockMode == clock_gen_pkg::MODE_LOCK_INT && divideFactor == 8'h02);
  bypass_c: cover property (clockMode == clock_gen_pkg::MODE_BYPASS_EXT);
  irq_clear_c: cover property (irqRequest ##1 !irqRequest);
  reset_req_c: cover property (resetRequest);

endmodule  // clock_gen_config

`default_nettype wire

// ===== rtl/clock_gen_pkg.sv
/*
  Constants for the clock generator configuration block: register offsets,
  field positions, reset values, mode codes and frequency figures.
  Assumes a 32-bit APB with byte addresses; each register is one aligned word.
*/
`default_nettype none

package clock_gen_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] CTRL1_OFFSET = 8'h00;
  localparam logic [7:0] CTRL2_OFFSET = 8'h04;
  localparam logic [7:0] STATUS1_OFFSET = 8'h08;
  localparam logic [7:0] STATUS2_OFFSET = 8'h0C;
  localparam logic [7:0] TRIM_OFFSET = 8'h10;

  // ****************************************
  // field positions
  // ****************************************
  localparam int unsigned GAIN_BIT = 7;
  localparam int unsigned RANGE_BIT = 6;
  localparam int unsigned REFSEL_BIT = 5;
  localparam int unsigned MODE_HI = 4;
  localparam int unsigned MODE_LO = 3;
  localparam int unsigned STOPKEEP_BIT = 2;
  localparam int unsigned DETECT_OFF_BIT = 1;
  localparam int unsigned UNIMPL_BIT = 0;
  localparam int unsigned LOCK_RST_BIT = 7;
  localparam int unsigned MULT_HI = 6;
  localparam int unsigned MULT_LO = 4;
  localparam int unsigned CLK_RST_BIT = 3;
  localparam int unsigned DIV_HI = 2;
  localparam int unsigned DIV_LO = 0;
  localparam int unsigned IRQ_FLAG_BIT = 0;
  localparam int unsigned LOST_CLK_BIT = 2;
  localparam int unsigned LOCK_BIT = 3;
  localparam int unsigned LOST_LOCK_BIT = 4;
  localparam int unsigned STABLE_BIT = 0;

  // synchroniser lanes
  localparam int unsigned SYNC_LOCK = 0;
  localparam int unsigned SYNC_LOST = 1;
  localparam int unsigned SYNC_DCO = 2;
  localparam int unsigned SYNC_STOP = 3;
  localparam int unsigned SYNC_W = 4;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  localparam logic [7:0] CTRL2_RESET = 8'h00;
  localparam logic [7:0] TRIM_RESET = 8'h80;

  typedef enum logic [1:0] {
    MODE_SELF = 2'b00,
    MODE_LOCK_INT = 2'b01,
    MODE_BYPASS_EXT = 2'b10,
    MODE_LOCK_EXT = 2'b11
  } clock_mode_t;

  // ****************************************
  // frequency figures (Hz)
  // ****************************************
  localparam logic [31:0] SELF_CLOCK_HZ = 32'h007A_1200;  // 8 MHz
  localparam logic [31:0] REF_GEN_HZ = 32'h0003_B538;  // 243 kHz
  localparam logic [63:0] INT_REF_DIV = 64'h0000_0000_0000_0007;
  localparam logic [6:0] PRESCALE_LOW = 7'h40;
  localparam logic [6:0] PRESCALE_HIGH = 7'h01;
  localparam logic [6:0] PRESCALE_INT = 7'h40;
  localparam logic [4:0] MULT_BASE = 5'h04;
  localparam logic [63:0] TRIM_SPAN_BASE = 64'h0000_0000_0000_0180;
  localparam logic [63:0] TRIM_SPAN_DIV = 64'h0000_0000_0000_0200;

endpackage

`default_nettype wire
